// *** hdl/ufis_top.sv ***
// UART event flags, interrupt enables, thresholds and interrupt output.
//
// What this block does
// - Transmit-ready flag clears itself when condition ends.
// - Receive-ready sets when level exceeds threshold.
// - Receive-ready also sets after threshold-scaled idle.
// - Receive-ready clears on zero write below threshold.
// - Receive threshold code gives trigger level.
// - Data buffer read pops, write pushes.
`timescale 1ns/1ns
`default_nettype none
module ufis_top (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output var  logic [7:0] rdata,
  input  wire logic [3:0] rxLevel,
  input  wire logic [3:0] txLevel,
  input  wire logic [7:0] rxHeadByte,
  input  wire logic       rxLineIdle,
  input  wire logic       bitTick,
  input  wire logic       rxOverflowEvt,
  input  wire logic       rxUnderflowEvt,
  input  wire logic       txOverflowEvt,
  input  wire logic       framingErrEvt,
  input  wire logic       txDoneEvt,
  output var  logic       irq,
  output var  logic       rxPop,
  output var  logic       txPush,
  output var  logic [7:0] txByte,
  output var  logic       rxFifoClr,
  output var  logic       txFifoClr
);

  // Stored state.
  logic [6:0] flags_q;
  logic [6:0] flags_d;
  logic [6:0] enables_q;
  logic [6:0] enables_d;
  logic       master_q;
  logic [3:0] rxThr_q;
  logic [3:0] txThr_q;
  logic [6:0] irqStat_q;
  logic [6:0] irqStat_d;
  logic [6:0] irqMask_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       irq_q;
  logic       rxPop_q;
  logic       txPush_q;
  logic [7:0] txByte_q;
  logic       rxFifoClr_q;
  logic       txFifoClr_q;
  logic       master_d;
  logic [3:0] rxThr_d;
  logic [3:0] txThr_d;
  logic [6:0] irqMask_d;
  logic [7:0] txByte_d;

  // Decoded accesses.
  logic       wrFlags;
  logic       wrThresh;
  logic       wrData;
  logic       wrMask;
  logic       rdFlags;
  logic       rdThresh;
  logic       rdData;
  logic       rdStat;
  logic       rdMask;

  // Conditions and events.
  logic       txBelow;
  logic       rxAbove;
  logic       rxBelow;
  logic       rxClrNow;
  logic       txClrNow;
  logic       rxRdyClr;
  logic [4:0] evtIn;
  logic [4:0] evtFifoClr;
  logic [6:0] flagRise;

  ufis_idle_if idl ();

  // Address decode for the register port.
  assign wrFlags  = wrStb && (addr == ufis_pkg::ADDR_FLAGS);
  assign wrThresh = wrStb && (addr == ufis_pkg::ADDR_THRESH);
  assign wrData   = wrStb && (addr == ufis_pkg::ADDR_DATABUF);
  assign wrMask   = wrStb && (addr == ufis_pkg::ADDR_IRQMASK);
  assign rdFlags  = rdStb && (addr == ufis_pkg::ADDR_FLAGS);
  assign rdThresh = rdStb && (addr == ufis_pkg::ADDR_THRESH);
  assign rdData   = rdStb && (addr == ufis_pkg::ADDR_DATABUF);
  assign rdStat   = rdStb && (addr == ufis_pkg::ADDR_IRQSTAT);
  assign rdMask   = rdStb && (addr == ufis_pkg::ADDR_IRQMASK);

  // Every threshold code is loaded as the trigger level; the two reset codes also clear a FIFO.
  assign rxClrNow = wrThresh &&
                    (wdata[ufis_pkg::RX_THR_LSB +: 4] == ufis_pkg::RX_CLR_CODE);
  assign txClrNow = wrThresh &&
                    (wdata[ufis_pkg::TX_THR_LSB +: 4] == ufis_pkg::TX_CLR_CODE);

  // Level comparisons against the programmed trigger levels.
  assign txBelow = (txLevel < txThr_q);
  assign rxAbove = (rxLevel > rxThr_q);
  assign rxBelow = (rxLevel < rxThr_q);

  // The idle timer only runs while unread bytes sit below the threshold.
  assign idl.bitTick  = bitTick;
  assign idl.lineIdle = rxLineIdle;
  assign idl.pending  = rxBelow && (rxLevel != 4'h0);
  assign idl.rxThr    = rxThr_q;

  ufis_idle_timer u_idle (
    .clk   (clk),
    .rst_n (rst_n),
    .idl   (idl.timer)
  );

  // Receive-ready clears only below threshold, by a zero written to its bit.
  assign rxRdyClr = wrFlags && !wdata[ufis_pkg::BIT_RXRDY] && rxBelow;

  // Event sources in bit order four down to zero.
  assign evtIn      = {rxOverflowEvt, rxUnderflowEvt, txOverflowEvt, framingErrEvt,
                       txDoneEvt};
  assign evtFifoClr = {rxFifoClr_q, rxFifoClr_q, txFifoClr_q, 1'b0, 1'b0};

  // Transmit-ready simply follows its condition, so software never clears it.
  assign flags_d[ufis_pkg::BIT_TXRDY] = txBelow;

  // Receive-ready: setting causes win over a clear in the same cycle.
  assign flags_d[ufis_pkg::BIT_RXRDY] = rxAbove || idl.timeout ? 1'b1 :
                                        rxRdyClr ? 1'b0 :
                                        flags_q[ufis_pkg::BIT_RXRDY];

  // Sticky event flags; a zero write clears them, and the owning FIFO reset clears the overflow and underflow flags.
  generate
    for (genvar i = 0; i < ufis_pkg::NUM_EVENT; i++) begin : g_evt
      assign flags_d[i] = evtIn[i] ? 1'b1 :
                          ((wrFlags && !wdata[i]) || evtFifoClr[i]) ? 1'b0 : flags_q[i];
    end
  endgenerate

  // A write stores all enables; a zero also disables that interrupt.
  assign enables_d = wrFlags ? wdata[6:0] : enables_q;
  assign master_d  = wrFlags ? wdata[ufis_pkg::BIT_MASTER] : master_q;

  // Loads are muxes in front of the flops, so every register updates on every edge.
  assign rxThr_d   = wrThresh ? wdata[ufis_pkg::RX_THR_LSB +: 4] : rxThr_q;
  assign txThr_d   = wrThresh ? wdata[ufis_pkg::TX_THR_LSB +: 4] : txThr_q;
  assign irqMask_d = wrMask ? wdata[6:0] : irqMask_q;
  assign txByte_d  = wrData ? wdata : txByte_q;

  // Status bits stick on any rising enabled flag, ready or event; a read clears them.
  assign flagRise  = flags_d & ~flags_q & enables_q;
  assign irqStat_d = flagRise | (rdStat ? ufis_pkg::IRQ_RST : irqStat_q);

  // Read mux; unmapped addresses read as zero.
  assign rdata_d = rdFlags  ? {master_q, flags_q} :
                   rdThresh ? {rxLevel, txLevel} :
                   rdData   ? rxHeadByte :
                   rdStat   ? {1'b0, irqStat_q} :
                   rdMask   ? {1'b0, irqMask_q} : ufis_pkg::RDATA_RST;

  // Flag, enable and threshold storage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q   <= ufis_pkg::FLAGS_RST[6:0];
      enables_q <= ufis_pkg::ENABLES_RST;
      master_q  <= 1'b0;
      rxThr_q   <= ufis_pkg::THRESH_RST;
      txThr_q   <= ufis_pkg::THRESH_RST;
    end else begin
      flags_q   <= flags_d;
      enables_q <= enables_d;
      master_q  <= master_d;
      rxThr_q   <= rxThr_d;
      txThr_q   <= txThr_d;
    end
  end

  // Interrupt status, mask and the level output.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStat_q <= ufis_pkg::IRQ_RST;
      irqMask_q <= ufis_pkg::IRQ_RST;
      irq_q     <= 1'b0;
    end else begin
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
      irq_q <= master_q && |(irqStat_q & irqMask_q);
    end
  end

  // Read data and FIFO side strobes, each registered for clean outputs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q     <= ufis_pkg::RDATA_RST;
      rxPop_q     <= 1'b0;
      txPush_q    <= 1'b0;
      txByte_q    <= ufis_pkg::RDATA_RST;
      rxFifoClr_q <= 1'b0;
      txFifoClr_q <= 1'b0;
    end else begin
      rdata_q     <= rdata_d;
      rxPop_q     <= rdData;
      txPush_q    <= wrData;
      rxFifoClr_q <= rxClrNow;
      txFifoClr_q <= txClrNow;
      txByte_q    <= txByte_d;
    end
  end

  assign rdata     = rdata_q;
  assign irq       = irq_q;
  assign rxPop     = rxPop_q;
  assign txPush    = txPush_q;
  assign txByte    = txByte_q;
  assign rxFifoClr = rxFifoClr_q;
  assign txFifoClr = txFifoClr_q;

  // Checks on the flags, status, interrupt and register port; the level inputs are sampled, so each
  // relation looks one edge back at its cause.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  tx_ready_track_a: assert property (
    ##1 flags_q[ufis_pkg::BIT_TXRDY] == $past(txLevel < txThr_q))
    else $error("Transmit-ready flag does not follow its level condition.");

  rx_ready_set_a: assert property (
    rxAbove |=> flags_q[ufis_pkg::BIT_RXRDY])
    else $error("Receive-ready flag not set above threshold.");

  idle_report_a: assert property (
    idl.timeout |=> flags_q[ufis_pkg::BIT_RXRDY])
    else $error("Idle timeout did not set receive-ready.");

  rx_ready_hold_a: assert property (
    flags_q[ufis_pkg::BIT_RXRDY] && !rxRdyClr |=> flags_q[ufis_pkg::BIT_RXRDY])
    else $error("Receive-ready flag dropped without a clearing write.");

  rx_ready_clear_a: assert property (
    rxRdyClr && !rxAbove && !idl.timeout
      |=> !flags_q[ufis_pkg::BIT_RXRDY] && !enables_q[ufis_pkg::BIT_RXRDY])
    else $error("Zero write below threshold did not clear flag and enable.");

  flag_readback_a: assert property (
    rdFlags |=> rdata == {$past(master_q), $past(flags_q)})
    else $error("Flag register read returned wrong contents.");

  rx_clear_code_a: assert property (
    rxClrNow |=> rxFifoClr ##1 !flags_q[ufis_pkg::BIT_RXOVF] || $past(rxOverflowEvt))
    else $error("Receive reset code did not clear the receive FIFO.");

  data_pop_a: assert property (
    rdData |=> rxPop && rdata == $past(rxHeadByte))
    else $error("Data buffer read did not pop the oldest byte.");

  data_push_a: assert property (
    wrData |=> txPush && txByte == $past(wdata) ##1 !txPush || $past(wrData))
    else $error("Data buffer write did not push one byte.");

  // A master or mask write may legally drop the line two cycles on, so those are left out.
  irq_level_a: assert property (
    master_q && |(irqStat_q & irqMask_q) && !rdStat && !wrFlags && !wrMask
      |=> irq ##1 irq)
    else $error("Interrupt output not held while a masked-in status bit stands.");

  tx_ready_drop_a: assert property (
    txLevel >= txThr_q |=> !flags_q[ufis_pkg::BIT_TXRDY])
    else $error("Transmit-ready flag stayed up with its condition gone.");

  event_set_a: assert property (
    evtIn != 5'h00 |=> (flags_q[4:0] & $past(evtIn)) == $past(evtIn))
    else $error("Event pulse did not set its flag.");

  event_clear_a: assert property (
    wrFlags && !wdata[ufis_pkg::BIT_TXDONE] && !txDoneEvt
      |=> !flags_q[ufis_pkg::BIT_TXDONE])
    else $error("Zero write did not clear the transmit-complete flag.");

  stat_set_a: assert property (
    flagRise != 7'h00 |=> (irqStat_q & $past(flagRise)) == $past(flagRise))
    else $error("Rising enabled flag did not set its status bit.");

  stat_clear_a: assert property (
    rdStat && flagRise == 7'h00 |=> irqStat_q == ufis_pkg::IRQ_RST)
    else $error("Status read did not clear the status bits.");

  mask_write_a: assert property (
    wrMask |=> irqMask_q == $past(wdata[6:0]))
    else $error("Mask write did not land.");

  irq_master_off_a: assert property (
    !master_q |=> !irq)
    else $error("Interrupt raised with the master enable off.");

  tx_clear_code_a: assert property (
    txClrNow |=> txFifoClr ##1 !flags_q[ufis_pkg::BIT_TXOVF] || $past(txOverflowEvt))
    else $error("Transmit reset code did not clear the transmit FIFO.");

  unmapped_read_a: assert property (
    rdStb && !(rdFlags || rdThresh || rdData || rdStat || rdMask)
      |=> rdata == ufis_pkg::RDATA_RST)
    else $error("Unmapped address did not read as zero.");

endmodule : ufis_top
`default_nettype wire

// *** include/ufis_pkg.sv ***
// Shared constants for the UART event flag and interrupt enable block.
package ufis_pkg;

  // Register offsets on the processor-side port.
  localparam logic [7:0] ADDR_THRESH  = 8'hB3;
  localparam logic [7:0] ADDR_FLAGS   = 8'hB4;
  localparam logic [7:0] ADDR_DATABUF = 8'hB5;
  localparam logic [7:0] ADDR_IRQSTAT = 8'hB8;
  localparam logic [7:0] ADDR_IRQMASK = 8'hB9;

  // Values after reset.
  localparam logic [7:0] FLAGS_RST   = 8'h00;
  localparam logic [6:0] ENABLES_RST = 7'h00;
  localparam logic [3:0] THRESH_RST  = 4'h0;
  localparam logic [6:0] IRQ_RST     = 7'h00;
  localparam logic [7:0] RDATA_RST   = 8'h00;

  // Bit positions in the flag and enable register.
  localparam int BIT_MASTER = 7;
  localparam int BIT_TXRDY  = 6;
  localparam int BIT_RXRDY  = 5;
  localparam int BIT_RXOVF  = 4;
  localparam int BIT_RXUNF  = 3;
  localparam int BIT_TXOVF  = 2;
  localparam int BIT_FRAMING_ERROR_FLAG   = 1;
  localparam int BIT_TXDONE = 0;
  localparam int NUM_EVENT  = 5;

  // Threshold register field positions.
  localparam int RX_THR_LSB = 4;
  localparam int TX_THR_LSB = 0;

  // Threshold codes that also reset a FIFO; they are still loaded as the level.
  localparam logic [3:0] RX_CLR_CODE = 4'hF;
  localparam logic [3:0] TX_CLR_CODE = 4'h0;

  // Idle timeout is threshold times two to this power bit periods.
  localparam int          IDLE_MULT_SHIFT = 4;
  localparam logic [8:0]  IDLE_CNT_RST    = 9'h000;

endpackage : ufis_pkg

// *** include/ufis_idle_if.sv ***
// Signals between the flag logic and the receive idle timer.
`timescale 1ns/1ns
`default_nettype none
interface ufis_idle_if;
  logic       bitTick;
  logic       lineIdle;
  logic       pending;
  logic [3:0] rxThr;
  logic       timeout;

  modport flags (output bitTick, output lineIdle, output pending, output rxThr,
                 input timeout);
  modport timer (input bitTick, input lineIdle, input pending, input rxThr,
                 output timeout);
endinterface : ufis_idle_if
`default_nettype wire

// *** hdl/ufis_idle_timer.sv ***
// Receive idle timer that reports leftover bytes below the threshold.
`timescale 1ns/1ns
`default_nettype none
module ufis_idle_timer (
  input  wire logic   clk,
  input  wire logic   rst_n,
  ufis_idle_if.timer  idl
);

  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic       timeout_q;
  logic       timeout_d;
  logic [8:0] limit;
  logic       armed;
  logic       atLimit;

  // Limit is the threshold times sixteen bit periods; counting past it fires once.
  assign limit   = {1'b0, idl.rxThr, 4'h0};
  assign armed   = idl.pending && idl.lineIdle;
  assign atLimit = (cnt_q == limit);
  assign cnt_d   = !armed ? ufis_pkg::IDLE_CNT_RST :
                   (idl.bitTick && (cnt_q <= limit)) ? cnt_q + 9'h001 : cnt_q;
  assign timeout_d = armed && idl.bitTick && atLimit;
  assign idl.timeout = timeout_q;

  // The count saturates one past the limit so the report is a single pulse.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q     <= ufis_pkg::IDLE_CNT_RST;
      timeout_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      timeout_q <= timeout_d;
    end
  end

endmodule : ufis_idle_timer
`default_nettype wire

// *** bench/ufis_top_test.sv ***
// Self-checking bench for the UART event flag and interrupt enable block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module ufis_top_test;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wrStb = 1'b0;
  logic       rdStb = 1'b0;
  logic [7:0] rdata;
  logic [3:0] rxLevel = 4'h0;
  logic [3:0] txLevel = 4'hF;
  logic [7:0] rxHeadByte = 8'h3C;
  logic       rxLineIdle = 1'b0;
  logic       bitTick = 1'b0;
  logic [4:0] evts = 5'h00;
  logic       irq, rxPop, txPush, rxFifoClr, txFifoClr;
  logic [7:0] txByte;
  int         bad_count = 0;
  int         checks = 0;

  // Events are grouped so that a loop reaches each flag by its bit position.
  ufis_top u_ufis_top (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .rxLevel(rxLevel), .txLevel(txLevel),
    .rxHeadByte(rxHeadByte), .rxLineIdle(rxLineIdle), .bitTick(bitTick),
    .rxOverflowEvt(evts[4]), .rxUnderflowEvt(evts[3]), .txOverflowEvt(evts[2]),
    .framingErrEvt(evts[1]), .txDoneEvt(evts[0]), .irq(irq), .rxPop(rxPop),
    .txPush(txPush), .txByte(txByte), .rxFifoClr(rxFifoClr), .txFifoClr(txFifoClr));

  // Clock of 50 MHz.
  always #10 clk = ~clk;

  // Prints the verdict and ends the run.
  task automatic summarize;
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // Waits whole cycles, then steps past the edge so outputs have settled.
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  // One-cycle write strobe; a gap cycle follows so strobes never merge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // Reset values and unmapped places.
  task automatic t_reset;
    logic [7:0] d;
    rd(ufis_pkg::ADDR_FLAGS, d); `CHK(d, 8'h00)
    rd(ufis_pkg::ADDR_IRQMASK, d); `CHK(d, 8'h00)
    wr(8'hB6, 8'h5A);
    rd(8'hB6, d); `CHK(d, 8'h00)
  endtask : t_reset

  // Transmit-ready follows the level with no software help, boundary included.
  task automatic t_txrdy;
    logic [7:0] d;
    wr(ufis_pkg::ADDR_THRESH, 8'h24);
    @(posedge clk) txLevel <= 4'h3;
    idle(2); rd(ufis_pkg::ADDR_FLAGS, d); `CHK(d[6], 1'b1)
    @(posedge clk) txLevel <= 4'h4;
    idle(2); rd(ufis_pkg::ADDR_FLAGS, d); `CHK(d[6], 1'b0)
    @(posedge clk) txLevel <= 4'hF;
  endtask : t_txrdy

  // Every threshold code 1 to 14: set strictly above, zero write clears only below.
  task automatic t_rxrdy;
    logic [7:0] d;
    for (int c = 1; c < 15; c++) begin
      wr(ufis_pkg::ADDR_THRESH, {c[3:0], 4'h4});
      @(posedge clk) rxLevel <= c[3:0];
      idle(2); rd(ufis_pkg::ADDR_FLAGS, d); `CHK(d[5], 1'b0)
      @(posedge clk) rxLevel <= c[3:0] + 4'h1;
      idle(2); rd(ufis_pkg::ADDR_FLAGS, d); `CHK(d[5], 1'b1)
      wr(ufis_pkg::ADDR_FLAGS, 8'h00);
      rd(ufis_pkg::ADDR_FLAGS, d); `CHK(d[5], 1'b1)
      @(posedge clk) rxLevel <= 4'h0;
      wr(ufis_pkg::ADDR_FLAGS, 8'h00);
      rd(ufis_pkg::ADDR_FLAGS, d); `CHK(d[5], 1'b0)
    end
  endtask : t_rxrdy

  // Threshold 2 gives a 32 bit-period idle limit; only the tick after it fires.
  task automatic t_idle;
    logic [7:0] d;
    wr(ufis_pkg::ADDR_THRESH, 8'h24);
    @(posedge clk) rxLevel <= 4'h1;
    rxLineIdle <= 1'b1;
    for (int k = 0; k < 33; k++) begin
      if (k == 32) begin
        rd(ufis_pkg::ADDR_FLAGS, d); `CHK(d[5], 1'b0)
      end
      @(posedge clk) bitTick <= 1'b1;
      @(posedge clk) bitTick <= 1'b0;
    end
    idle(2); rd(ufis_pkg::ADDR_FLAGS, d); `CHK(d[5], 1'b1)
    @(posedge clk) rxLineIdle <= 1'b0;
    wr(ufis_pkg::ADDR_FLAGS, 8'h00);
    rd(ufis_pkg::ADDR_FLAGS, d); `CHK(d[5], 1'b0)
    @(posedge clk) rxLevel <= 4'h0;
  endtask : t_idle

  // Each event raises its flag and the interrupt; a zero write clears the flag.
  task automatic t_events;
    logic [7:0] d, m;
    wr(ufis_pkg::ADDR_IRQMASK, 8'h7F);
    wr(ufis_pkg::ADDR_FLAGS, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      m = 8'h01 << i;
      @(posedge clk) evts[i] <= 1'b1;
      @(posedge clk) evts <= 5'h00;
      idle(3); `CHK(irq, 1'b1)
      rd(ufis_pkg::ADDR_IRQSTAT, d); `CHK(d, m)
      idle(2); `CHK(irq, 1'b0)
      rd(ufis_pkg::ADDR_FLAGS, d); `CHK(d & (m | 8'h80), m | 8'h80)
      wr(ufis_pkg::ADDR_FLAGS, ~m);
      rd(ufis_pkg::ADDR_FLAGS, d); `CHK(d & m, 8'h00)
      wr(ufis_pkg::ADDR_FLAGS, 8'hFF);
    end
    // The mask holds the line low; the master enable gates it as well.
    wr(ufis_pkg::ADDR_IRQMASK, 8'h00);
    @(posedge clk) evts[0] <= 1'b1;
    @(posedge clk) evts <= 5'h00;
    idle(3); `CHK(irq, 1'b0)
    wr(ufis_pkg::ADDR_IRQMASK, 8'h7F);
    idle(2); `CHK(irq, 1'b1)
    wr(ufis_pkg::ADDR_FLAGS, 8'h7F);
    idle(2); `CHK(irq, 1'b0)
    rd(ufis_pkg::ADDR_IRQSTAT, d);
  endtask : t_events

  // Data buffer pops and pushes, level reads at the threshold address and the FIFO clear codes.
  task automatic t_buffer;
    logic [7:0] d;
    wr(ufis_pkg::ADDR_DATABUF, 8'hA5);
    #1 `CHK({txPush, txByte}, 9'h1A5)
    rd(ufis_pkg::ADDR_DATABUF, d); `CHK({rxPop, d}, 9'h13C)
    idle(1); `CHK({rxPop, txPush}, 2'h0)
    wr(ufis_pkg::ADDR_THRESH, 8'hF4);
    #1 `CHK({rxFifoClr, txFifoClr}, 2'h2)
    wr(ufis_pkg::ADDR_THRESH, 8'h20);
    #1 `CHK({rxFifoClr, txFifoClr}, 2'h1)
    @(posedge clk) rxLevel <= 4'h3;
    rd(ufis_pkg::ADDR_THRESH, d); `CHK(d, 8'h3F)
  endtask : t_buffer

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_txrdy();
    t_rxrdy();
    t_idle();
    t_events();
    t_buffer();
    summarize();
  end
endmodule : ufis_top_test
`default_nettype wire
